// ### tb/modem_lines_monitor.sv
`timescale 1ns/1ps
// ==============================================================
// Checker on the modem line and transmit-space ports.
module modem_lines_monitor #(parameter CHANNELS = 4)
(
	input wire ref_clk,
	input wire rst,
	input wire [7:0] address,
	input wire write,
	input wire [31:0] writedata,
	input wire waitrequest,
	input wire [CHANNELS*7-1:0] tx_level,
	input wire [CHANNELS-1:0] cts_n,
	input wire [CHANNELS-1:0] ri_n,
	input wire [CHANNELS-1:0] dtr_n,
	input wire [CHANNELS-1:0] rts_n,
	input wire [CHANNELS-1:0] tx_space_avail_n,
	input wire tx_space_any_n,
	input wire [CHANNELS-1:0] tx_allow,
	input wire irq
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire wr0 = write && !waitrequest && address == 8'h00;
	AST_ROOM: assert property (!$past(rst) && $past(tx_level[6:0]) < 7'd64
		|-> !tx_space_avail_n[0]) else $error("room not flagged");
	AST_FULL: assert property (!$past(rst) && $past(tx_level[6:0]) == 7'd64
		|-> tx_space_avail_n[0]) else $error("full not flagged");
	AST_ANY: assert property (!$past(rst) |->
		tx_space_any_n == &tx_space_avail_n) else $error("combined flag wrong");
	AST_DTR: assert property (wr0 |-> ##2 dtr_n[0] == !$past(writedata[0], 2))
		else $error("dtr does not follow control");
	AST_RTS: assert property (wr0 && writedata[1] |-> ##2 !rts_n[0])
		else $error("rts not driven low");
	AST_RST: assert property ($past(rst) |-> &dtr_n && &rts_n && !irq)
		else $error("outputs not idle after reset");
	AST_CTS: assert property (!$past(rst) && !tx_allow[0] |-> $past(cts_n[0], 3))
		else $error("transmit held without cts");
	AST_RING: assert property ($rose(ri_n[0]) |-> ##[3:5] irq)
		else $error("ring end gave no interrupt");
	cover property (wr0);
	cover property ($rose(irq));
	cover property (!$past(rst) && tx_space_any_n);
endmodule

bind modem_lines modem_lines_monitor #(.CHANNELS(CHANNELS)) u_mon (.ref_clk,
	.rst, .address, .write, .writedata, .waitrequest, .tx_level, .cts_n,
	.ri_n, .dtr_n, .rts_n, .tx_space_avail_n, .tx_space_any_n, .tx_allow, .irq);

// ### tb/modem_lines_test.sv
`timescale 1ns/1ps
module modem_lines_test;
	reg ref_clk = 1'b0;
	reg rst = 1'b1;
	reg read = 1'b0;
	reg write = 1'b0;
	reg [7:0] address = 8'h00;
	reg [31:0] writedata = 32'h0;
	reg [27:0] tx_level = 28'h0;
	reg [3:0] rx_above_thresh = 4'h0;
	reg [15:0] want = 16'hffff;
	reg [3:0] lag = 4'h0;
	reg [31:0] rd;
	reg [31:0] wd;
	reg [6:0] lv [0:3];
	integer n_fail = 0;
	integer cmp_count = 0;
	integer i;
	integer c;
	wire [31:0] readdata;
	wire waitrequest, tx_space_any_n, irq;
	wire [3:0] cd_n, cts_n, dsr_n, ri_n, dtr_n, rts_n, tx_space_avail_n, tx_allow;
	always #5 ref_clk = ~ref_clk;
	modem_lines u_dut (.ref_clk, .rst, .address, .read, .write, .writedata,
		.readdata, .waitrequest, .tx_level, .cd_n, .cts_n, .dsr_n, .ri_n,
		.rx_above_thresh, .dtr_n, .rts_n, .tx_space_avail_n,
		.tx_space_any_n, .tx_allow, .irq);
	modem_model u_modem (.ref_clk, .want, .lag, .cd_n, .cts_n, .dsr_n, .ri_n);
	function [3:0] room;
		input integer k;
	begin
		for (k = 0; k < 4; k = k + 1)
			room[k] = lv[k] < 7'd64;
	end
	endfunction
	task close_out;
	begin
		if (n_fail == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	end
	endtask
	task chk(input [31:0] seen, input [31:0] exp);
	begin
		cmp_count = cmp_count + 1;
		if (seen !== exp)
		begin
			n_fail = n_fail + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	end
	endtask
	task bus(input w, input [7:0] a, input [31:0] d);
	begin
		read <= !w;
		write <= w;
		address <= a;
		writedata <= d;
		@(posedge ref_clk);
		while (waitrequest !== 1'b0)
			@(posedge ref_clk);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		repeat (3) @(posedge ref_clk);
	end
	endtask
	initial
	begin
		#200000;
		n_fail = n_fail + 1;
		close_out;
	end
	initial
	begin
		i = $urandom(32'hc3befd7d);
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		chk({dtr_n, rts_n, tx_space_avail_n, irq}, 13'h1ffe);
		bus(1'b1, 8'h44, 32'hf);
		for (i = 0; i < 14; i = i + 1)
		begin
			c = i % 4;
			wd = $urandom % 4;
			bus(1'b1, {c[3:0], 4'h0}, wd);
			chk({dtr_n[c], rts_n[c]}, {~wd[0], ~wd[1]});
			for (c = 0; c < 4; c = c + 1)
				lv[c] = (i < 2) ? 7'd64 - (i[0] & c[0]) : $urandom % 65;
			tx_level <= {lv[3], lv[2], lv[1], lv[0]};
			bus(1'b0, {i[1:0], 4'hc}, 32'h0);
			chk(rd, {lv[i % 4] < 7'd64, 1'b0, lv[i % 4]});
			chk({tx_space_any_n, tx_space_avail_n}, {room(0) == 0, ~room(0)});
			want <= $urandom;
			lag <= $urandom % 4;
			repeat (12) @(posedge ref_clk);
			bus(1'b0, {i[1:0], 4'h4}, 32'h0);
			c = i % 4;
			chk(rd, {~want[c], ~want[12 + c], ~want[8 + c], ~want[4 + c], 4'h0});
			chk(tx_allow, 4'hf);
		end
		bus(1'b1, 8'h08, 32'h80);
		bus(1'b1, 8'h18, 32'h40);
		bus(1'b1, 8'h10, 32'h2);
		for (i = 0; i < 4; i = i + 1)
		begin
			want <= {7'h7f, i[1], 3'h7, i[0], 4'hf};
			rx_above_thresh <= {2'h0, i[0], 1'b0};
			repeat (12) @(posedge ref_clk);
			chk({tx_allow[0], rts_n[1]}, {!i[0], i[0]});
		end
		bus(1'b1, 8'h40, 32'hf);
		chk(irq, 1'b0);
		for (i = 0; i < 2; i = i + 1)
		begin
			want <= {i[0] ? 4'hf : 4'h0, 12'hfff};
			repeat (12) @(posedge ref_clk);
			chk(irq, i[0]);
		end
		bus(1'b0, 8'h40, 32'h0);
		chk(rd, 32'hf);
		bus(1'b1, 8'h44, 32'h0);
		chk(irq, 1'b0);
		bus(1'b1, 8'h44, 32'h2);
		chk(irq, 1'b1);
		bus(1'b1, 8'h40, 32'hf);
		bus(1'b0, 8'h80, 32'h0);
		chk(rd, 32'h0);
		chk(irq, 1'b0);
		close_out;
	end
endmodule

// ### tb/modem_model.sv
`timescale 1ns/1ps
// ==============================================================
// Modem side: moves its lines to the asked levels after a set lag.
module modem_model (
	input wire ref_clk,
	input wire [15:0] want,
	input wire [3:0] lag,
	output reg [3:0] cd_n = 4'hf,
	output reg [3:0] cts_n = 4'hf,
	output reg [3:0] dsr_n = 4'hf,
	output reg [3:0] ri_n = 4'hf
);
	reg [3:0] cnt_r = 4'h0;
	always @(posedge ref_clk)
	begin
		cnt_r <= ({ri_n, dsr_n, cts_n, cd_n} == want) ? 4'h0 : cnt_r + 4'h1;
		if (cnt_r >= lag)
			{ri_n, dsr_n, cts_n, cd_n} <= want;
	end
endmodule

// ### verilog/line_sync.v
`timescale 1ns/1ps
`include "modem_lines_defines.vh"

// ==============================================================
// Two-stage synchroniser for a group of asynchronous levels.
module line_sync #(
	parameter WIDTH = 4,
	parameter [WIDTH-1:0] INIT = {WIDTH{1'b1}}
)
(
	input wire ref_clk,
	input wire rst,
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);

	reg [WIDTH-1:0] meta_r;

	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			meta_r <= INIT;
			sync_out <= INIT;
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end

endmodule

// ### verilog/modem_lines.v
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "modem_lines_defines.vh"

module modem_lines #(
	parameter CHANNELS = 4,
	parameter FIFO_DEPTH = 64
)
(
	input wire ref_clk,
	input wire rst,
	// Avalon-MM slave.
	input wire [7:0] address,
	input wire read,
	input wire write,
	input wire [31:0] writedata,
	output reg [31:0] readdata,
	output reg waitrequest,
	// Transmit buffer occupancy from each channel's FIFO, packed.
	input wire [CHANNELS*7-1:0] tx_level,
	// Active-low modem inputs.
	input wire [CHANNELS-1:0] cd_n,
	input wire [CHANNELS-1:0] cts_n,
	input wire [CHANNELS-1:0] dsr_n,
	input wire [CHANNELS-1:0] ri_n,
	// Receive FIFO above its auto RTS threshold, per channel.
	input wire [CHANNELS-1:0] rx_above_thresh,
	// Active-low modem outputs.
	output reg [CHANNELS-1:0] dtr_n,
	output reg [CHANNELS-1:0] rts_n,
	output reg [CHANNELS-1:0] tx_space_avail_n,
	output reg tx_space_any_n,
	// Transmitter may start a new character.
	output reg [CHANNELS-1:0] tx_allow,
	output reg irq
);

	// ==============================================================
	// Synchronised modem inputs.
	wire [CHANNELS-1:0] cd_s;
	wire [CHANNELS-1:0] cts_s;
	wire [CHANNELS-1:0] dsr_s;
	wire [CHANNELS-1:0] ri_s;

	line_sync #(.WIDTH(4*CHANNELS), .INIT({4*CHANNELS{1'b1}})) u_sync
	(
		.ref_clk(ref_clk),
		.rst(rst),
		.async_in({cd_n, cts_n, dsr_n, ri_n}),
		.sync_out({cd_s, cts_s, dsr_s, ri_s})
	);

	// ==============================================================
	// Channel registers.
	reg [7:0] modem_control_reg [0:CHANNELS-1];
	reg [7:0] enhanced_feature_reg [0:CHANNELS-1];
	reg [CHANNELS-1:0] ri_prev_r;
	reg [CHANNELS-1:0] irq_stat_r;
	reg [CHANNELS-1:0] irq_mask_r;
	reg [CHANNELS-1:0] space_r;

	wire [CHANNELS-1:0] ri_rise;
	assign ri_rise = ri_s & ~ri_prev_r;

	// Decoded access.
	wire [1:0] ch_sel;
	wire [3:0] reg_off;
	wire in_ch;
	assign ch_sel = address[5:4];
	assign reg_off = address[3:0];
	assign in_ch = (address < CHANNELS * `CH_STRIDE);

	wire [CHANNELS-1:0] clr_bits;
	assign clr_bits = (write && !waitrequest &&
		address == `OFF_IRQ_STAT) ? writedata[CHANNELS-1:0] :
		{CHANNELS{1'b0}};

	integer i;
	integer j;

	// ==============================================================
	// Space detection per channel.
	always @*
	begin
		for (j = 0; j < CHANNELS; j = j + 1)
			space_r[j] = (tx_level[j*7 +: 7] < FIFO_DEPTH);
	end

	// ==============================================================
	// Register writes, events and outputs.
	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			for (i = 0; i < CHANNELS; i = i + 1)
			begin
				modem_control_reg[i] <= `CTRL_RESET;
				enhanced_feature_reg[i] <= `FEAT_RESET;
			end
			ri_prev_r <= {CHANNELS{1'b1}};
			irq_stat_r <= {CHANNELS{1'b0}};
			irq_mask_r <= {CHANNELS{1'b0}};
			dtr_n <= {CHANNELS{1'b1}};
			rts_n <= {CHANNELS{1'b1}};
			tx_space_avail_n <= {CHANNELS{1'b1}};
			tx_space_any_n <= 1'b1;
			tx_allow <= {CHANNELS{1'b0}};
			irq <= 1'b0;
		end
		else
		begin
			if (write && !waitrequest)
			begin
				if (in_ch && reg_off == `OFF_MDM_CTRL)
					modem_control_reg[ch_sel] <= writedata[7:0];
				else if (in_ch && reg_off == `OFF_FEAT)
					enhanced_feature_reg[ch_sel] <= writedata[7:0];
				else if (address == `OFF_IRQ_MASK)
					irq_mask_r <= writedata[CHANNELS-1:0];
			end
			ri_prev_r <= ri_s;
			// A new ring edge wins over a simultaneous clear.
			irq_stat_r <= (irq_stat_r & ~clr_bits) | ri_rise;
			irq <= |(((irq_stat_r & ~clr_bits) | ri_rise) & irq_mask_r);
			for (i = 0; i < CHANNELS; i = i + 1)
			begin
				// DTR follows control bit 0 only; no flow control use.
				dtr_n[i] <= ~modem_control_reg[i][`CTRL_DTR];
				// Auto RTS also drops the request when receive is above its threshold.
				if (enhanced_feature_reg[i][`FEAT_AUTO_RTS])
					rts_n[i] <= ~(modem_control_reg[i][`CTRL_RTS] &
						~rx_above_thresh[i]);
				else
					rts_n[i] <= ~modem_control_reg[i][`CTRL_RTS];
				// Clear-to-send stalls the transmitter only in auto mode.
				if (enhanced_feature_reg[i][`FEAT_AUTO_CTS])
					tx_allow[i] <= ~cts_s[i];
				else
					tx_allow[i] <= 1'b1;
				tx_space_avail_n[i] <= ~space_r[i];
			end
			tx_space_any_n <= ~(|space_r);
		end
	end

	// ==============================================================
	// Bus answers: one wait cycle, then the read data.
	reg [31:0] rdata_nxt;

	always @*
	begin
		rdata_nxt = 32'h00000000;
		if (in_ch && reg_off == `OFF_MDM_CTRL)
			rdata_nxt[7:0] = modem_control_reg[ch_sel];
		else if (in_ch && reg_off == `OFF_MDM_STAT)
		begin
			// Status bits show asserted lines as ones.
			rdata_nxt[`STAT_CTS] = ~cts_s[ch_sel];
			rdata_nxt[`STAT_DSR] = ~dsr_s[ch_sel];
			rdata_nxt[`STAT_RI] = ~ri_s[ch_sel];
			rdata_nxt[`STAT_CD] = ~cd_s[ch_sel];
		end
		else if (in_ch && reg_off == `OFF_FEAT)
			rdata_nxt[7:0] = enhanced_feature_reg[ch_sel];
		else if (in_ch && reg_off == `OFF_TXLVL)
		begin
			rdata_nxt[6:0] = tx_level[ch_sel*7 +: 7];
			rdata_nxt[8] = space_r[ch_sel];
		end
		else if (address == `OFF_IRQ_STAT)
			rdata_nxt[CHANNELS-1:0] = irq_stat_r;
		else if (address == `OFF_IRQ_MASK)
			rdata_nxt[CHANNELS-1:0] = irq_mask_r;
		else if (address == `OFF_TXSPACE)
			rdata_nxt[CHANNELS-1:0] = space_r;
	end

	always @(posedge ref_clk)
	begin
		if (rst)
		begin
			waitrequest <= 1'b1;
			readdata <= 32'h00000000;
		end
		else
		begin
			// Release one cycle after a request appears, then re-arm.
			waitrequest <= !((read || write) && waitrequest);
			if (read && waitrequest)
				readdata <= rdata_nxt;
		end
	end

endmodule

// ### verilog/modem_lines_defines.vh
`ifndef MODEM_LINES_DEFINES_VH
`define MODEM_LINES_DEFINES_VH

// Byte offsets of each channel's register window.
`define CH_STRIDE 8'h10
`define OFF_MDM_CTRL 8'h00
`define OFF_MDM_STAT 8'h04
`define OFF_FEAT 8'h08
`define OFF_TXLVL 8'h0c
// Shared interrupt and transmit-space registers.
`define OFF_IRQ_STAT 8'h40
`define OFF_IRQ_MASK 8'h44
`define OFF_TXSPACE 8'h48

// Modem control register fields.
`define CTRL_DTR 0
`define CTRL_RTS 1
// Modem status register fields.
`define STAT_CTS 4
`define STAT_DSR 5
`define STAT_RI 6
`define STAT_CD 7
// Enhanced feature register fields.
`define FEAT_AUTO_RTS 6
`define FEAT_AUTO_CTS 7

`define CTRL_RESET 8'h00
`define FEAT_RESET 8'h00
`define MASK_RESET 8'h00

// Synchroniser depth for the modem status inputs.
`define SYNC_STAGES 2

`endif
